//--- hw/irq_map.svh
// Register offsets, field positions, reset values and vectors of the
// two-level interrupt controller. Included by the controller only.
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

`define IRQ_OFS_ENABLE    8'h00
`define IRQ_OFS_PRIORITY  8'h04
`define IRQ_OFS_GROUP     8'h08
`define IRQ_OFS_SYSMASK   8'h0C
`define IRQ_OFS_TIMER     8'h10
`define IRQ_OFS_SERIAL    8'h14
`define IRQ_OFS_SYSFLAG   8'h18
`define IRQ_OFS_COUNTER   8'h1C
`define IRQ_OFS_STATUS    8'h20

`define IRQ_RST_BYTE      8'h00

`define EN_GLOBAL_BIT     7
`define GRP_USB_BIT       7
`define GRP_CA_BIT        1
`define GRP_SF_BIT        0
`define MSK_BUSDET_BIT    7
`define TMR_TF1_BIT       7
`define TMR_TF0_BIT       5
`define TMR_IE1_BIT       3
`define TMR_IT1_BIT       2
`define TMR_IE0_BIT       1
`define TMR_IT0_BIT       0
`define SER_RX_BIT        0
`define SER_TX_BIT        1
`define SER_MASK_BIT      6
`define SER_ROUTE_BIT     7
`define SF_START_BIT      4
`define SF_STOP_BIT       5
`define CNT_CMP_BIT       0
`define CNT_OVF_BIT       7
`define STS_INS_LOW_BIT   8
`define STS_INS_HIGH_BIT  9
`define STS_IDX_LSB       12
`define STS_VALID_BIT     15

`define USB_FLAG_W        13

`define VEC_EXT0          16'h0003
`define VEC_TMR0          16'h000B
`define VEC_EXT1          16'h0013
`define VEC_TMR1          16'h001B
`define VEC_SERIAL        16'h0023
`define VEC_GROUP         16'h002B

`endif

//--- hw/irq_pkg.sv
// Types shared by the interrupt controller and its priority resolver.
// Assumes nothing beyond a SystemVerilog compiler.
package irq_pkg;

  typedef logic [5:0] src_vec_t;   // One bit per source, polling order
  typedef logic [2:0] src_idx_t;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage

//--- hw/irq_arb_if.sv
// Carrier between the controller and its priority resolver.
// Assumes both ends sit on the same clock.
interface irq_arb_if;
  irq_pkg::src_vec_t req;        // Sampled enabled requests
  irq_pkg::src_vec_t prio_high;  // Per-source high-level select
  logic              ins_high;   // High-level service in progress
  logic              ins_low;    // Low-level service in progress
  logic              win_valid;
  irq_pkg::src_idx_t win_idx;

  modport arb (input req, prio_high, ins_high, ins_low, output win_valid, win_idx);
  modport ctl (output req, prio_high, ins_high, ins_low, input win_valid, win_idx);
endinterface

//--- hw/irq_arbiter.sv
// Two-level priority resolver with fixed polling order inside a level.
// Assumes requests already sampled and enable-gated by the controller.
module irq_arbiter (
  input wire logic ref_clk,   // System clock
  input wire logic reset,     // Async reset, active high
  irq_arb_if.arb   arb        // Request and winner carrier
);

  irq_pkg::src_vec_t elig_high;
  irq_pkg::src_vec_t elig_low;

  // A running high service blocks everything; a low one blocks only low
  always_comb begin
    elig_high = arb.req & arb.prio_high & {6{~arb.ins_high}};
    elig_low  = arb.req & ~arb.prio_high & {6{~arb.ins_high & ~arb.ins_low}};
  end

  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_idx   = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (elig_low[i]) begin
        arb.win_valid = 1'b1;
        arb.win_idx   = i[2:0];
      end
    end
    // High level overrides any low candidate
    for (int i = 5; i >= 0; i--) begin
      if (elig_high[i]) begin
        arb.win_valid = 1'b1;
        arb.win_idx   = i[2:0];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_first_source_wins: assert property (elig_high[0] |-> arb.win_valid && arb.win_idx == 3'h0)
    else $error("external 0 lost polling at high level");
  a_high_beats_low: assert property (|elig_high && |elig_low |-> arb.prio_high[arb.win_idx])
    else $error("low level request beat high level");

endmodule

//--- hw/irq_controller.sv
// Two-level interrupt controller: flags, enables, priority, vectoring.
// Assumes an Avalon-MM master for registers and a CPU core that raises
// instr_final on each instruction's last cycle and pulses irq_ack / reti_done.
`include "irq_map.svh"

module irq_controller (
  input  wire logic        ref_clk,          // System clock, 100 MHz
  input  wire logic        reset,            // Async reset, active high
  input  wire logic [7:0]  address,          // Avalon byte address
  input  wire logic        read,             // Avalon read
  input  wire logic        write,            // Avalon write
  input  wire logic [31:0] writedata,        // Avalon write data
  input  wire logic [3:0]  byteenable,       // Avalon byte lanes
  output logic      [31:0] readdata,         // Avalon read data
  output logic             waitrequest,      // Avalon stall
  input  wire logic        ext_pin0_n,       // External interrupt 0 pin
  input  wire logic        ext_pin1_n,       // External interrupt 1 pin
  input  wire logic        tmr0_ovf_evt,     // Timer 0 rollover pulse
  input  wire logic        tmr1_ovf_evt,     // Timer 1 rollover pulse
  input  wire logic        rx_done_evt,      // Serial receive complete pulse
  input  wire logic        tx_done_evt,      // Serial transmit complete pulse
  input  wire logic [5:0]  sysflag_evt,      // System flag event pulses
  input  wire logic        counter_ovf_evt,  // Counter array overflow pulse
  input  wire logic        compare_evt,      // Compare/capture module pulse
  input  wire logic [12:0] usb_event_flags,  // USB engine flags, level
  input  wire logic        instr_final,      // Final cycle of instruction
  input  wire logic        reti_done,        // Return from service completes
  input  wire logic        irq_ack,          // CPU takes the vectored call
  output logic             irq_request,      // Vectored call wanted
  output logic      [15:0] irq_vector        // Service entry address
);

  irq_arb_if arb_bus ();

  irq_arbiter u_arbiter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .arb     (arb_bus.arb)
  );

  function automatic logic [15:0] vector_of(input irq_pkg::src_idx_t idx);
    case (idx)
      3'h0:    vector_of = `VEC_EXT0;
      3'h1:    vector_of = `VEC_TMR0;
      3'h2:    vector_of = `VEC_EXT1;
      3'h3:    vector_of = `VEC_TMR1;
      3'h4:    vector_of = `VEC_SERIAL;
      default: vector_of = `VEC_GROUP;
    endcase
  endfunction

  // Register state
  logic [7:0]        enable_reg, priority_select, group_reg, sysflag_mask_reg;
  logic [7:0]        timer_ctrl_reg, serial_reg, sysflag_reg, counter_reg;
  logic [7:0]        next_enable, next_priority, next_group, next_sysmask;
  logic [7:0]        next_timer, next_serial, next_sysflag, next_counter;
  // Bus and vectoring state
  irq_pkg::bus_state_t bus_state, next_bus_state;
  logic [31:0]       next_readdata;
  logic [1:0]        pin_q, next_pin_q;
  irq_pkg::src_vec_t sampled_req, next_sampled;
  logic              poll_valid, next_poll_valid;
  irq_pkg::src_idx_t poll_idx, next_poll_idx;
  logic [15:0]       next_vector;
  logic              ins_high, ins_low, next_ins_high, next_ins_low;
  logic              cfg_block, next_cfg_block;
  // Combinational
  logic              bus_wr_en, lane0, cfg_write, take;
  logic              ext0_fall, ext1_fall, sysflag_sub, ca_sub, usb_sub;
  irq_pkg::src_vec_t raw_req, enabled_req;

  assign lane0     = byteenable[0];
  assign waitrequest = (read | write) & (bus_state != irq_pkg::BUS_ANSWER);
  assign bus_wr_en = write & ~waitrequest & lane0;
  assign cfg_write = bus_wr_en & ((address == `IRQ_OFS_ENABLE) | (address == `IRQ_OFS_PRIORITY));
  assign take      = irq_ack & irq_request;
  assign ext0_fall = pin_q[0] & ~ext_pin0_n;
  assign ext1_fall = pin_q[1] & ~ext_pin1_n;

  // Request tree
  always_comb begin
    sysflag_sub = group_reg[`GRP_SF_BIT] & (
      |(sysflag_reg[3:0] & sysflag_mask_reg[3:0]) |
      ((sysflag_reg[`SF_START_BIT] | sysflag_reg[`SF_STOP_BIT]) & sysflag_mask_reg[`MSK_BUSDET_BIT]) |
      (serial_reg[`SER_TX_BIT] & serial_reg[`SER_ROUTE_BIT]));
    ca_sub  = group_reg[`GRP_CA_BIT] & (counter_reg[`CNT_OVF_BIT] | counter_reg[`CNT_CMP_BIT]);
    usb_sub = group_reg[`GRP_USB_BIT] & (|usb_event_flags);
    raw_req[0] = timer_ctrl_reg[`TMR_IE0_BIT];
    raw_req[1] = timer_ctrl_reg[`TMR_TF0_BIT];
    raw_req[2] = timer_ctrl_reg[`TMR_IE1_BIT];
    raw_req[3] = timer_ctrl_reg[`TMR_TF1_BIT];
    raw_req[4] = serial_reg[`SER_RX_BIT] |
                 (serial_reg[`SER_TX_BIT] & ~serial_reg[`SER_MASK_BIT] & ~serial_reg[`SER_ROUTE_BIT]);
    raw_req[5] = sysflag_sub | ca_sub | usb_sub;
    enabled_req = raw_req & enable_reg[5:0] & {6{enable_reg[`EN_GLOBAL_BIT]}};
  end

  // Flag and configuration registers
  always_comb begin
    next_enable   = enable_reg;
    next_priority = priority_select;
    next_group    = group_reg;
    next_sysmask  = sysflag_mask_reg;
    next_timer    = timer_ctrl_reg;
    next_serial   = serial_reg;
    next_sysflag  = sysflag_reg;
    next_counter  = counter_reg;
    next_pin_q    = {ext_pin1_n, ext_pin0_n};
    if (bus_wr_en) begin
      case (address)
        `IRQ_OFS_ENABLE:   next_enable   = writedata[7:0] & 8'hBF;
        `IRQ_OFS_PRIORITY: next_priority = {2'b00, writedata[5:0]};
        `IRQ_OFS_GROUP:    next_group    = writedata[7:0] & 8'h83;
        `IRQ_OFS_SYSMASK:  next_sysmask  = writedata[7:0] & 8'h8F;
        `IRQ_OFS_TIMER:    next_timer    = writedata[7:0] & 8'hAF;
        `IRQ_OFS_SERIAL:   next_serial   = writedata[7:0] & 8'hC3;
        `IRQ_OFS_SYSFLAG:  next_sysflag  = {2'b00, writedata[5:0]};
        `IRQ_OFS_COUNTER:  next_counter  = writedata[7:0] & 8'h81;
        default: ;
      endcase
    end
    // Vectoring clears: timers always, external only when edge triggered
    if (take && poll_idx == 3'h1) next_timer[`TMR_TF0_BIT] = 1'b0;
    if (take && poll_idx == 3'h3) next_timer[`TMR_TF1_BIT] = 1'b0;
    if (take && poll_idx == 3'h0 && timer_ctrl_reg[`TMR_IT0_BIT]) next_timer[`TMR_IE0_BIT] = 1'b0;
    if (take && poll_idx == 3'h2 && timer_ctrl_reg[`TMR_IT1_BIT]) next_timer[`TMR_IE1_BIT] = 1'b0;
    // Hardware sets last so a set wins over a clear in the same cycle
    if (tmr0_ovf_evt) next_timer[`TMR_TF0_BIT] = 1'b1;
    if (tmr1_ovf_evt) next_timer[`TMR_TF1_BIT] = 1'b1;
    if (timer_ctrl_reg[`TMR_IT0_BIT]) begin
      if (ext0_fall) next_timer[`TMR_IE0_BIT] = 1'b1;
    end else begin
      next_timer[`TMR_IE0_BIT] = ~ext_pin0_n;
    end
    if (timer_ctrl_reg[`TMR_IT1_BIT]) begin
      if (ext1_fall) next_timer[`TMR_IE1_BIT] = 1'b1;
    end else begin
      next_timer[`TMR_IE1_BIT] = ~ext_pin1_n;
    end
    if (rx_done_evt) next_serial[`SER_RX_BIT] = 1'b1;
    if (tx_done_evt) next_serial[`SER_TX_BIT] = 1'b1;
    next_sysflag[5:0] = next_sysflag[5:0] | sysflag_evt;
    if (counter_ovf_evt) next_counter[`CNT_OVF_BIT] = 1'b1;
    if (compare_evt) next_counter[`CNT_CMP_BIT] = 1'b1;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enable_reg       <= `IRQ_RST_BYTE;
      priority_select  <= `IRQ_RST_BYTE;
      group_reg        <= `IRQ_RST_BYTE;
      sysflag_mask_reg <= `IRQ_RST_BYTE;
      timer_ctrl_reg   <= `IRQ_RST_BYTE;
      serial_reg       <= `IRQ_RST_BYTE;
      sysflag_reg      <= `IRQ_RST_BYTE;
      counter_reg      <= `IRQ_RST_BYTE;
      pin_q            <= 2'b11;
    end else begin
      enable_reg       <= next_enable;
      priority_select  <= next_priority;
      group_reg        <= next_group;
      sysflag_mask_reg <= next_sysmask;
      timer_ctrl_reg   <= next_timer;
      serial_reg       <= next_serial;
      sysflag_reg      <= next_sysflag;
      counter_reg      <= next_counter;
      pin_q            <= next_pin_q;
    end
  end

  // Avalon slave: one wait cycle, then the answer
  always_comb begin
    next_bus_state = irq_pkg::BUS_IDLE;
    next_readdata  = readdata;
    case (bus_state)
      irq_pkg::BUS_IDLE: begin
        if (read | write) next_bus_state = irq_pkg::BUS_ANSWER;
        if (read) begin
          case (address)
            `IRQ_OFS_ENABLE:   next_readdata = {24'h00_0000, enable_reg};
            `IRQ_OFS_PRIORITY: next_readdata = {24'h00_0000, priority_select};
            `IRQ_OFS_GROUP:    next_readdata = {24'h00_0000, group_reg};
            `IRQ_OFS_SYSMASK:  next_readdata = {24'h00_0000, sysflag_mask_reg};
            `IRQ_OFS_TIMER:    next_readdata = {24'h00_0000, timer_ctrl_reg};
            `IRQ_OFS_SERIAL:   next_readdata = {24'h00_0000, serial_reg};
            `IRQ_OFS_SYSFLAG:  next_readdata = {24'h00_0000, sysflag_reg};
            `IRQ_OFS_COUNTER:  next_readdata = {24'h00_0000, counter_reg};
            `IRQ_OFS_STATUS: begin
              next_readdata = 32'h0000_0000;
              next_readdata[5:0] = sampled_req;
              next_readdata[`STS_INS_LOW_BIT]  = ins_low;
              next_readdata[`STS_INS_HIGH_BIT] = ins_high;
              next_readdata[`STS_IDX_LSB +: 3] = poll_idx;
              next_readdata[`STS_VALID_BIT]    = poll_valid;
            end
            default: next_readdata = 32'h0000_0000;
          endcase
        end
      end
      irq_pkg::BUS_ANSWER: next_bus_state = irq_pkg::BUS_IDLE;
      default: next_bus_state = irq_pkg::BUS_IDLE;
    endcase
  end

  // Sample, poll, service tracking
  always_comb begin
    arb_bus.req       = sampled_req;
    arb_bus.prio_high = priority_select[5:0];
    arb_bus.ins_high  = ins_high;
    arb_bus.ins_low   = ins_low;
    next_sampled      = enabled_req;
    next_poll_valid   = arb_bus.win_valid & ~take;
    next_poll_idx     = arb_bus.win_idx;
    next_vector       = vector_of(arb_bus.win_idx);
    next_ins_high     = ins_high;
    next_ins_low      = ins_low;
    // Withheld from a config write or return until an instruction completes
    next_cfg_block    = cfg_block;
    if (instr_final) next_cfg_block = 1'b0;
    if (cfg_write | reti_done) next_cfg_block = 1'b1;
    if (reti_done) begin
      if (ins_high) next_ins_high = 1'b0;
      else next_ins_low = 1'b0;
    end
    if (take) begin
      if (priority_select[poll_idx]) next_ins_high = 1'b1;
      else next_ins_low = 1'b1;
    end
  end

  // Current enables gate again so a cleared enable stops a stale poll
  assign irq_request = poll_valid & instr_final & ~cfg_block & ~cfg_write & ~reti_done &
                       enabled_req[poll_idx] &
                       ~ins_high & (priority_select[poll_idx] | ~ins_low);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_state   <= irq_pkg::BUS_IDLE;
      readdata    <= 32'h0000_0000;
      sampled_req <= 6'h00;
      poll_valid  <= 1'b0;
      poll_idx    <= 3'h0;
      irq_vector  <= `VEC_EXT0;
      ins_high    <= 1'b0;
      ins_low     <= 1'b0;
      cfg_block   <= 1'b0;
    end else begin
      bus_state   <= next_bus_state;
      readdata    <= next_readdata;
      sampled_req <= next_sampled;
      poll_valid  <= next_poll_valid;
      poll_idx    <= next_poll_idx;
      irq_vector  <= next_vector;
      ins_high    <= next_ins_high;
      ins_low     <= next_ins_low;
      cfg_block   <= next_cfg_block;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_cfg_write;
    write && !waitrequest && lane0 && address == `IRQ_OFS_ENABLE;
  endsequence
  sequence s_take_tmr0;
    take && poll_idx == 3'h1 && !tmr0_ovf_evt && !bus_wr_en;
  endsequence

  a_global_blocks_all: assert property (!enable_reg[`EN_GLOBAL_BIT] |-> !irq_request)
    else $error("request while global enable clear");
  a_own_enable_needed: assert property (irq_request |-> enable_reg[poll_idx])
    else $error("request from a disabled source");
  a_vector_matches: assert property (irq_request |-> irq_vector == vector_of(poll_idx))
    else $error("vector does not match winner");
  a_group_vector: assert property (irq_request && poll_idx == 3'h5 |-> irq_vector == 16'h002B)
    else $error("group vector wrong");
  a_timer_cleared: assert property (s_take_tmr0 |=> !timer_ctrl_reg[`TMR_TF0_BIT])
    else $error("timer 0 flag survived vectoring");
  a_edge_cleared: assert property (take && poll_idx == 3'h0 && timer_ctrl_reg[`TMR_IT0_BIT]
                                   && !ext0_fall && !bus_wr_en |=> !timer_ctrl_reg[`TMR_IE0_BIT])
    else $error("edge flag survived vectoring");
  a_level_follows: assert property (!timer_ctrl_reg[`TMR_IT0_BIT] ##1 !$past(timer_ctrl_reg[`TMR_IT0_BIT])
                                    |-> timer_ctrl_reg[`TMR_IE0_BIT] == !$past(ext_pin0_n))
    else $error("level flag does not follow pin");
  a_serial_kept: assert property (take && poll_idx == 3'h4 && serial_reg[`SER_RX_BIT] && !bus_wr_en
                                  |=> serial_reg[`SER_RX_BIT])
    else $error("serial flag cleared by vectoring");
  a_high_no_preempt: assert property (ins_high |-> !irq_request)
    else $error("request during high level service");
  a_final_cycle_only: assert property (irq_request |-> instr_final)
    else $error("request outside final cycle");
  a_cfg_write_block: assert property (s_cfg_write |-> !irq_request ##1 !irq_request)
    else $error("request right after enable write");
  a_ack_marks_service: assert property (take && !reti_done |=> ins_high || ins_low)
    else $error("ack did not mark service");

endmodule

//--- verification/cpu_core_model.sv
// CPU core stand-in: takes each call, serves it, then returns.
// Assumes the controller's single clock and its pulse-style link.
module cpu_core_model #(parameter int SVC_LEN = 8) (
  input  wire logic        ref_clk,      // System clock
  input  wire logic        reset,        // Async reset, active high
  input  wire logic        slow,         // Final cycle only every fourth
  input  wire logic        irq_request,  // Call wanted
  input  wire logic [15:0] irq_vector,   // Entry address
  output logic             instr_final,  // Last cycle of instruction
  output logic             irq_ack,      // Call taken
  output logic             reti_done,    // Return completes
  output logic      [15:0] last_vec,     // Vector of latest call
  output logic      [7:0]  acks,         // Calls taken
  output logic      [2:0]  depth         // Nesting depth
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  logic [7:0] left;
  // Ack in the same cycle, as a real core takes the call
  assign irq_ack = irq_request & instr_final;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ph <= 2'h0;
      instr_final <= 1'b0;
      reti_done <= 1'b0;
      last_vec <= 16'h0000;
      acks <= 8'h00;
      depth <= 3'h0;
      left <= 8'h00;
    end else begin
      ph <= ph + 2'h1;
      instr_final <= !slow || ph == 2'h2;
      reti_done <= 1'b0;
      if (irq_ack) begin
        last_vec <= irq_vector;
        acks <= acks + 8'h01;
        depth <= depth + 3'h1;
        left <= SVC_LEN[7:0];
      end else if (depth != 3'h0 && left == 8'h00) begin
        reti_done <= 1'b1;
        depth <= depth - 3'h1;
        left <= SVC_LEN[7:0];
      end else if (depth != 3'h0) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the interrupt controller.
// Assumes the CPU core stand-in is compiled before it.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  fofs [6] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h14, 8'h1C};
  localparam logic [7:0]  fset [6] = '{8'h03, 8'h20, 8'h0C, 8'h80, 8'h01, 8'h01};
  localparam logic [7:0]  faft [6] = '{8'h01, 8'h00, 8'h04, 8'h00, 8'h01, 8'h01};
  localparam logic [15:0] fvec [6] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
  localparam int          hk [8]   = '{0, 1, 2, 3, 4, 8, 10, 11};
  localparam logic [15:0] hv [8]   = '{16'h000B, 16'h001B, 16'h0023, 16'h0023, 16'h002B, 16'h002B, 16'h002B,
                                       16'h002B};
  logic        ref_clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, pin0_n = 1'b1, slow = 1'b0;
  logic        pin1_n = 1'b1;
  logic [7:0]  address = 8'h00, wdata = 8'h00, seen = 8'h00, acks;
  logic [24:0] ev = 25'h000_0000;
  logic [31:0] readdata, q;
  logic [15:0] irq_vector, last_vec;
  logic [2:0]  depth;
  logic        waitrequest, irq_request, instr_final, irq_ack, reti_done;
  int          fails = 0, checked = 0;

  always #5 ref_clk = ~ref_clk;

  irq_controller dut (.ref_clk, .reset, .address, .read, .write, .writedata({24'h00_0000, wdata}),
    .byteenable(4'hF), .readdata, .waitrequest, .ext_pin0_n(pin0_n), .ext_pin1_n(pin1_n),
    .tmr0_ovf_evt(ev[0]), .tmr1_ovf_evt(ev[1]), .rx_done_evt(ev[2]), .tx_done_evt(ev[3]),
    .sysflag_evt(ev[9:4]), .counter_ovf_evt(ev[10]), .compare_evt(ev[11]), .usb_event_flags(ev[24:12]),
    .instr_final, .reti_done, .irq_ack, .irq_request, .irq_vector);
  cpu_core_model cpu (.ref_clk, .reset, .slow, .irq_request, .irq_vector, .instr_final, .irq_ack,
    .reti_done, .last_vec, .acks, .depth);

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge ref_clk);
    address <= a;
    wdata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) fails++;
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(q, {24'h00_0000, e});
  endtask
  task automatic take(input logic [15:0] e);
    int n = 0;
    while (acks === seen && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    // No call taken within the limit is a mismatch
    if (acks === seen) fails++;
    seen = acks;
    check({16'h0000, last_vec}, {16'h0000, e});
  endtask
  // Disable, clear every flag, then let service unwind
  task automatic clr;
    int n = 0;
    wr(8'h00, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'h10 + 8'(i * 4), 8'h00);
    while (depth !== 3'h0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (depth !== 3'h0) fails++;
    seen = acks;
  endtask
  task automatic wrap_up;
    $display("Mismatches %0d, checks %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    wr(8'h00, 8'h7F);
    rd(8'h00, 8'h3F);
    wr(8'h24, 8'hFF);
    rd(8'h24, 8'h00);
    wr(8'h08, 8'h83);
    wr(8'h0C, 8'hFF);
    clr;
    slow <= 1'b1;
    wr(8'h10, 8'h20);
    wr(8'h00, 8'h80);
    repeat (20) @(posedge ref_clk);
    wr(8'h00, 8'h02);
    repeat (20) @(posedge ref_clk);
    check({24'h00_0000, acks}, {24'h00_0000, seen});
    wr(8'h00, 8'h82);
    take(16'h000B);
    clr;
    slow <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      // Type bit must be edge mode before a written pin flag sticks
      repeat (2) wr(fofs[i], fset[i]);
      wr(8'h00, 8'h80 | (8'h01 << i));
      take(fvec[i]);
      wr(8'h00, 8'h00);
      rd(fofs[i], faft[i]);
      clr;
    end
    wr(8'h10, 8'hA0);
    wr(8'h00, 8'h8A);
    take(16'h000B);
    clr;
    wr(8'h04, 8'h08);
    wr(8'h10, 8'hA0);
    wr(8'h00, 8'h8A);
    take(16'h001B);
    clr;
    wr(8'h04, 8'h00);
    pin0_n <= 1'b0;
    wr(8'h00, 8'h81);
    take(16'h0003);
    wr(8'h00, 8'h00);
    rd(8'h10, 8'h02);
    pin0_n <= 1'b1;
    clr;
    pin1_n <= 1'b0;
    wr(8'h00, 8'h84);
    take(16'h0013);
    wr(8'h00, 8'h00);
    rd(8'h10, 8'h08);
    pin1_n <= 1'b1;
    clr;
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h81);
    pin0_n <= 1'b0;
    take(16'h0003);
    wr(8'h00, 8'h00);
    rd(8'h10, 8'h01);
    pin0_n <= 1'b1;
    clr;
    for (int j = 0; j < 8; j++) begin
      wr(8'h00, 8'hBF);
      ev <= 25'h000_0001 << hk[j];
      @(posedge ref_clk);
      ev <= 25'h000_0000;
      take(hv[j]);
      clr;
    end
    // Masked tx and a disabled counter array sub-source must stay silent
    wr(8'h14, 8'h40);
    wr(8'h08, 8'h01);
    wr(8'h00, 8'hB0);
    ev <= 25'h000_0808;
    @(posedge ref_clk);
    ev <= 25'h000_0000;
    repeat (20) @(posedge ref_clk);
    check({24'h00_0000, acks}, {24'h00_0000, seen});
    rd(8'h14, 8'h42);
    rd(8'h1C, 8'h01);
    wr(8'h08, 8'h83);
    clr;
    // Routed tx must reach the group vector, not the serial one
    wr(8'h14, 8'h80);
    wr(8'h00, 8'hB0);
    ev <= 25'h000_0008;
    @(posedge ref_clk);
    ev <= 25'h000_0000;
    take(16'h002B);
    clr;
    // USB flags are levels held by their engine
    wr(8'h00, 8'hA0);
    ev <= 25'h100_0000;
    take(16'h002B);
    ev <= 25'h000_0000;
    clr;
    wrap_up;
  end

  // Whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    wrap_up;
  end
endmodule
